/* design/adccr_pkg.sv */
// package: addresses, field positions, reset values and timing for the converter block
// assumes: byte-wide peripheral bus with absolute 16-bit addresses
`default_nettype none
package adccr_pkg;
   localparam logic [15:0] ADDR_CONTROL   = 16'h1070;
   localparam logic [15:0] ADDR_STATUS    = 16'h1071;
   localparam logic [15:0] ADDR_RESULT    = 16'h1072;
   localparam logic [15:0] ADDR_PIN_IN    = 16'h107D;
   localparam logic [15:0] ADDR_PIN_FUNC  = 16'h107E;
   localparam logic [15:0] ADDR_PRIORITY  = 16'h107F;
   // control fields
   localparam int CTL_CH_LSB       = 0;
   localparam int CTL_REF_LSB      = 3;
   localparam int CTL_SAMPLE_BIT   = 6;
   localparam int CTL_CONVERT_BIT  = 7;
   // status fields
   localparam int STS_IRQ_EN_BIT   = 0;
   localparam int STS_FLAG_BIT     = 1;
   localparam int STS_READY_BIT    = 2;
   // priority fields
   localparam int PRI_FREEZE_BIT   = 5;
   localparam int PRI_LEVEL_BIT    = 6;
   localparam int PRI_TEST_BIT     = 7;
   // reset values
   localparam logic [7:0] RST_CONTROL  = 8'h00;
   localparam logic [7:0] RST_PIN_FUNC = 8'h00;
   localparam logic [2:0] RST_PRIORITY = 3'h0;
   localparam logic [7:0] RST_RESULT   = 8'h00;
   // timing in system clock cycles after convert-start is written
   localparam int SAMPLE_END_CYCLES  = 18;
   localparam int CONVERT_END_CYCLES = 164;
   localparam int CNT_W              = 8;
endpackage : adccr_pkg
`default_nettype wire

/* design/adccr_timer.sv */
// cycle counter: counts from start, pulses at two marks, halts on abort or hold
// assumes: start, abort, hold are synchronous to mclk
`default_nettype none
module adccr_timer #(
   parameter int W       = adccr_pkg::CNT_W,
   parameter int MARK_A  = adccr_pkg::SAMPLE_END_CYCLES,
   parameter int MARK_B  = adccr_pkg::CONVERT_END_CYCLES
) (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         start,
   input  wire logic         abort,
   input  wire logic         hold,
   output logic              busy,
   output logic              hit_a,
   output logic              hit_b
);
   logic [W-1:0] count;

   // cycle 1 is the edge after the write; hits rise one edge early so the
   // register acting on them changes on edge n itself
   always_ff @(posedge mclk) begin
      if (rst || abort) begin
         count <= '0;
         busy  <= 1'b0;
      end else if (start) begin
         count <= W'(1);
         busy  <= 1'b1;
      end else if (busy && !hold) begin
         count <= count + W'(1);
         if (count == W'(MARK_B - 1)) begin
            busy <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || abort || start) begin
         hit_a <= 1'b0;
         hit_b <= 1'b0;
      end else begin
         hit_a <= busy && !hold && (count == W'(MARK_A - 2));
         hit_b <= busy && !hold && (count == W'(MARK_B - 2));
      end
   end
endmodule : adccr_timer
`default_nettype wire

/* design/adccr_top.sv */
// converter register and sequencing block: six byte registers, start sequencing,
// completion flag, interrupt routing, digital-input port
// assumes: single-cycle byte bus writes/reads, converter core returns result on done
// Summary of operation
// - control bits 0-2 pick analog input
// - change channel only after start bits clear
// - reference code 0 supply, else input n
// - sample-start write aborts and resamples
// - convert-start write begins conversion
// - start bits clear 18 cycles after convert
// - halt or standby clears starts, aborts
// - status bit 0 gates interrupt request
// - completion sets flag; flag and enable interrupt
// - flag clear only; halt, reset clear it
// - ready bit shows idle, resets one
// - result loads at end, holds until next
// - digital input reads pins, analog pins zero
// - pin function bits: 0 analog, 1 digital
// - suspend freeze bit stops converter when suspended
// - priority bit routes to level 1 or 2
// - priority bits written only in privilege mode
// - conversion completes 164 cycles after convert
// - request reasserts when enable set again
`default_nettype none
module adccr_top (
   input  wire logic         mclk,
   input  wire logic         rst,
   // peripheral bus
   input  wire logic [15:0]  bus_addr,
   input  wire logic         bus_wr,
   input  wire logic         bus_rd,
   input  wire logic [7:0]   bus_wdata,
   output logic       [7:0]  bus_rdata,
   input  wire logic         privilege_mode,
   // system modes
   input  wire logic         low_power_entry,
   input  wire logic         emu_suspend,
   // pins
   input  wire logic [7:0]   pin_level,
   // converter core
   input  wire logic [7:0]   core_result,
   output logic       [2:0]  core_channel,
   output logic       [2:0]  core_reference,
   output logic              core_sample,
   output logic              core_convert,
   output logic              core_ref_supply,
   output logic              core_frozen,
   // interrupt requests
   output logic              irq_level1,
   output logic              irq_level2
);
   logic [7:0] control;
   logic       irq_enable;
   logic       done_flag;
   logic [7:0] result;
   logic [7:0] pin_function;
   logic [7:0] pin_sampled;
   logic [2:0] priority_bits;
   logic       busy;
   logic       hit_sample_end;
   logic       hit_convert_end;
   logic       low_power_q;
   logic       low_power_edge;
   logic       wr_control;
   logic       wr_status;
   logic       wr_priority;
   logic       wr_pin_func;
   logic       start_convert;
   logic       start_sample;
   logic       freeze;
   logic       irq_req;
   logic [7:0] next_control;
   logic       next_done_flag;
   logic       next_irq_enable;
   logic [7:0] next_pin_function;
   logic [2:0] next_priority;
   logic [7:0] next_rdata;
   logic [7:0] status_byte;
   logic [7:0] priority_byte;
   logic [2:0] ctl_channel;
   logic [2:0] ctl_reference;
   logic       ctl_sample;
   logic       next_irq_level1;
   logic       next_irq_level2;
   logic       route_low;

   // write decode, one strobe per writable register
   always_comb begin
      wr_control  = 1'b0;
      wr_status   = 1'b0;
      wr_priority = 1'b0;
      wr_pin_func = 1'b0;
      if (bus_wr) begin
         unique case (bus_addr)
            adccr_pkg::ADDR_CONTROL:  wr_control  = 1'b1;
            adccr_pkg::ADDR_STATUS:   wr_status   = 1'b1;
            adccr_pkg::ADDR_PRIORITY: wr_priority = 1'b1;
            adccr_pkg::ADDR_PIN_FUNC: wr_pin_func = 1'b1;
            default: begin
               // result and digital input ignore writes
            end
         endcase
      end
   end

   // control fields and priority level bit as named signals
   assign ctl_channel   = control[adccr_pkg::CTL_CH_LSB +: 3];
   assign ctl_reference = control[adccr_pkg::CTL_REF_LSB +: 3];
   assign ctl_sample    = control[adccr_pkg::CTL_SAMPLE_BIT];
   assign route_low     = priority_bits[adccr_pkg::PRI_LEVEL_BIT - 5];

   // convert start edge
   // rewriting convert while still set does not restart the count
   assign start_convert = wr_control && bus_wdata[adccr_pkg::CTL_CONVERT_BIT]
                          && !control[adccr_pkg::CTL_CONVERT_BIT];
   assign start_sample  = wr_control && bus_wdata[adccr_pkg::CTL_SAMPLE_BIT]
                          && !bus_wdata[adccr_pkg::CTL_CONVERT_BIT];
   assign freeze = emu_suspend && priority_bits[adccr_pkg::PRI_FREEZE_BIT - 5];

   always_ff @(posedge mclk) begin
      if (rst) begin
         low_power_q <= 1'b0;
      end else begin
         low_power_q <= low_power_entry;
      end
   end
   assign low_power_edge = low_power_entry && !low_power_q;

   adccr_timer #(
      .W      (adccr_pkg::CNT_W),
      .MARK_A (adccr_pkg::SAMPLE_END_CYCLES),
      .MARK_B (adccr_pkg::CONVERT_END_CYCLES)
   ) u_timer (
      .mclk  (mclk),
      .rst   (rst),
      .start (start_convert),
      .abort (low_power_edge || start_sample),
      .hold  (freeze),
      .busy  (busy),
      .hit_a (hit_sample_end),
      .hit_b (hit_convert_end)
   );

   // control register; channel, reference
   always_comb begin
      next_control = control;
      if (low_power_edge) begin
         next_control = control & 8'h3F;
      end else if (wr_control) begin
         next_control = bus_wdata;
      end else if (hit_sample_end) begin
         next_control = control & 8'h3F;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         control <= adccr_pkg::RST_CONTROL;
      end else begin
         control <= next_control;
      end
   end

   always_comb begin
      next_irq_enable = irq_enable;
      if (wr_status) begin
         next_irq_enable = bus_wdata[adccr_pkg::STS_IRQ_EN_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_enable <= 1'b0;
      end else begin
         irq_enable <= next_irq_enable;
      end
   end

   always_comb begin
      next_done_flag = done_flag;
      if (wr_status && !bus_wdata[adccr_pkg::STS_FLAG_BIT]) begin
         next_done_flag = 1'b0;
      end
      if (hit_convert_end) begin
         next_done_flag = 1'b1;
      end
      if (low_power_edge) begin
         next_done_flag = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         done_flag <= 1'b0;
      end else begin
         done_flag <= next_done_flag;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         result <= adccr_pkg::RST_RESULT;
      end else if (hit_convert_end) begin
         result <= core_result;
      end
   end

   always_comb begin
      next_pin_function = pin_function;
      if (wr_pin_func) begin
         next_pin_function = bus_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_function <= adccr_pkg::RST_PIN_FUNC;
      end else begin
         pin_function <= next_pin_function;
      end
   end

   // digital pins, analog zero, one gate per pin
   for (genvar i = 0; i < 8; i++) begin : g_pin
      always_ff @(posedge mclk) begin
         if (rst) begin
            pin_sampled[i] <= 1'b0;
         end else begin
            pin_sampled[i] <= pin_level[i] && pin_function[i];
         end
      end
   end

   always_comb begin
      next_priority = priority_bits;
      if (wr_priority && privilege_mode) begin
         next_priority = bus_wdata[adccr_pkg::PRI_TEST_BIT:adccr_pkg::PRI_FREEZE_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         priority_bits <= adccr_pkg::RST_PRIORITY;
      end else begin
         priority_bits <= next_priority;
      end
   end

   assign irq_req = done_flag && irq_enable;

   always_comb begin
      next_irq_level1 = 1'b0;
      next_irq_level2 = 1'b0;
      if (irq_req) begin
         if (route_low) begin
            next_irq_level2 = 1'b1;
         end else begin
            next_irq_level1 = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_level1 <= 1'b0;
         irq_level2 <= 1'b0;
      end else begin
         irq_level1 <= next_irq_level1;
         irq_level2 <= next_irq_level2;
      end
   end

   // channel passes through live
   // a change while a start bit is set spoils the running conversion
   // supply reference on code 0
   always_ff @(posedge mclk) begin
      if (rst) begin
         core_channel    <= 3'h0;
         core_reference  <= 3'h0;
         core_sample     <= 1'b0;
         core_convert    <= 1'b0;
         core_ref_supply <= 1'b1;
         core_frozen     <= 1'b0;
      end else begin
         core_channel    <= ctl_channel;
         core_reference  <= ctl_reference;
         core_sample     <= ctl_sample;
         core_convert    <= busy;
         core_ref_supply <= (ctl_reference == 3'h0);
         core_frozen     <= freeze;
      end
   end

   // ready reflects idle; reserved bits read 0
   assign status_byte   = {5'h00, !busy, done_flag, irq_enable};
   // test bit stored and read back, reserved bits read 0
   assign priority_byte = {priority_bits, 5'h00};

   // register read mux; data holds until the next read
   always_comb begin
      next_rdata = bus_rdata;
      if (bus_rd) begin
         unique case (bus_addr)
            adccr_pkg::ADDR_CONTROL:   next_rdata = control;
            adccr_pkg::ADDR_STATUS:    next_rdata = status_byte;
            adccr_pkg::ADDR_RESULT:    next_rdata = result;
            adccr_pkg::ADDR_PIN_IN:    next_rdata = pin_sampled;
            adccr_pkg::ADDR_PIN_FUNC:  next_rdata = pin_function;
            adccr_pkg::ADDR_PRIORITY:  next_rdata = priority_byte;
            default:                   next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         bus_rdata <= 8'h00;
      end else begin
         bus_rdata <= next_rdata;
      end
   end
endmodule : adccr_top
`default_nettype wire

/* verification/adccr_assertions.sv */
// checker: port timing of the converter register block
// assumes: bound to adccr_top, one clock mclk, sync reset rst
`default_nettype none
module adccr_assertions (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic [15:0] bus_addr,
   input wire logic        bus_wr,
   input wire logic [7:0]  bus_wdata,
   input wire logic        low_power_entry,
   input wire logic        emu_suspend,
   input wire logic [2:0]  core_channel,
   input wire logic [2:0]  core_reference,
   input wire logic        core_sample,
   input wire logic        core_convert,
   input wire logic        core_ref_supply,
   input wire logic        core_frozen,
   input wire logic        irq_level1,
   input wire logic        irq_level2
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire logic ctl_wr = bus_wr && bus_addr == 16'h1070;
   // sample write without convert aborts
   wire logic abort_wr = ctl_wr && bus_wdata[6] && !bus_wdata[7];
   wire logic go_wr = ctl_wr && bus_wdata[7:6] == 2'b11 && core_sample && !core_convert;
   a_field_copy: assert property (
      ctl_wr |-> ##2 core_channel == $past(bus_wdata[2:0], 2)
      && core_reference == $past(bus_wdata[5:3], 2)) else $error("field copy");
   a_ref_supply: assert property (
      core_ref_supply == (core_reference == 3'h0)) else $error("ref supply");
   a_irq_single: assert property (
      !(irq_level1 && irq_level2)) else $error("two irq levels");
   a_sample_clear: assert property (
      disable iff (rst || low_power_entry || emu_suspend || abort_wr)
      go_wr |-> ##17 core_sample ##[1:4] !core_sample) else $error("sample clear");
   a_convert_len: assert property (
      disable iff (rst || low_power_entry || emu_suspend || abort_wr)
      go_wr |-> ##3 core_convert ##161 core_convert ##[1:3] !core_convert)
      else $error("convert length");
   a_flag_clear: assert property (
      bus_wr && bus_addr == 16'h1071 && !bus_wdata[1] |-> ##2 !irq_level1 && !irq_level2)
      else $error("irq after clear");
   a_low_power: assert property (
      $rose(low_power_entry) |-> ##3 !core_sample && !core_convert)
      else $error("low power abort");
   a_freeze_hold: assert property (
      disable iff (rst || low_power_entry)
      core_frozen && core_convert |=> core_convert) else $error("freeze hold");
endmodule : adccr_assertions
`default_nettype wire

/* verification/adccr_core_model.sv */
// partner: converter core giving a code built from the sampled selection
// assumes: block takes core_result while core_convert is high
`default_nettype none
module adccr_core_model (
   input  wire logic       mclk,
   input  wire logic [2:0] core_channel,
   input  wire logic [2:0] core_reference,
   input  wire logic       core_sample,
   input  wire logic       core_convert,
   output logic      [7:0] core_result
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] held;
   always_ff @(posedge mclk) begin
      if (core_sample) begin
         held <= {core_channel, core_reference, 2'h2};
      end
   end
   // outside a conversion the output is not valid
   assign core_result = core_convert ? held : ~held;
endmodule : adccr_core_model
`default_nettype wire

/* verification/test_adccr_top.sv */
// testbench: register traffic, conversions, aborts, freeze
// assumes: package, design, core model and checker compiled first
`default_nettype none
module test_adccr_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
   logic        privilege_mode = 1'b0, low_power_entry = 1'b0, emu_suspend = 1'b0;
   logic [15:0] bus_addr = 16'h0000;
   logic [7:0]  bus_wdata = 8'h00, pin_level = 8'h3C, bus_rdata, core_result;
   logic [2:0]  core_channel, core_reference;
   logic        core_sample, core_convert, core_ref_supply, core_frozen;
   logic        irq_level1, irq_level2;
   int          fails = 0, checks_done = 0;
   always #4 mclk = ~mclk;
   adccr_top u_dut (.mclk, .rst, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata,
      .privilege_mode, .low_power_entry, .emu_suspend, .pin_level, .core_result,
      .core_channel, .core_reference, .core_sample, .core_convert, .core_ref_supply,
      .core_frozen, .irq_level1, .irq_level2);
   adccr_core_model u_core (.mclk, .core_channel, .core_reference, .core_sample,
      .core_convert, .core_result);
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", w, e, g);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge mclk);
      bus_wr    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge mclk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge mclk);
      bus_rd   <= 1'b0;
      @(negedge mclk);
      v = bus_rdata;
   endtask : rd
   task automatic rc(input logic [15:0] a, input logic [7:0] e, input string w);
      logic [7:0] v;
      rd(a, v);
      chk(w, e, v);
   endtask : rc
   task automatic wait_flag;
      logic [7:0] v;
      for (int i = 0; i < 100; i++) begin
         rd(16'h1071, v);
         if (v[1] === 1'b1) return;
      end
      chk("flag wait", 8'h02, v);
      finish_test();
   endtask : wait_flag
   task automatic start(input logic [7:0] c);
      wr(16'h1070, {2'b01, c[5:0]});
      repeat (4) @(posedge mclk);
      wr(16'h1070, {2'b11, c[5:0]});
   endtask : start
   task automatic t_regs;
      rc(16'h1071, 8'h04, "status rst");
      rc(16'h107F, 8'h00, "prio rst");
      rc(16'h107D, 8'h00, "pin in rst");
      wr(16'h107E, 8'hA5);
      wr(16'h107D, 8'hFF);
      rc(16'h107E, 8'hA5, "pin func");
      rc(16'h107D, 8'h24, "pin in");
      wr(16'h107F, 8'h40);
      wr(16'h1071, 8'h06);
      rc(16'h107F, 8'h00, "prio unpriv");
      rc(16'h1071, 8'h04, "status set");
      wr(16'h107E, 8'h00);
   endtask : t_regs
   task automatic t_conv(input logic p);
      privilege_mode <= 1'b1;
      wr(16'h107F, {1'b0, p, 6'h00});
      wr(16'h1071, 8'h01);
      start(8'h1D);
      rc(16'h1071, 8'h01, "busy");
      repeat (16) @(posedge mclk);
      rc(16'h1070, 8'h1D, "starts clear");
      wr(16'h1070, 8'h1A);
      wait_flag();
      rc(16'h1072, 8'hAE, "result");
      chk("irq", {6'h00, p, !p}, {6'h00, irq_level2, irq_level1});
      wr(16'h1071, 8'h02);
      repeat (2) @(posedge mclk);
      chk("irq off", 8'h00, {6'h00, irq_level2, irq_level1});
      wr(16'h1071, 8'h03);
      repeat (2) @(posedge mclk);
      chk("irq back", {6'h00, p, !p}, {6'h00, irq_level2, irq_level1});
      wr(16'h1071, 8'h01);
      rc(16'h1071, 8'h05, "flag clear");
      rc(16'h1072, 8'hAE, "result hold");
   endtask : t_conv
   task automatic t_abort;
      start(8'h01);
      repeat (30) @(posedge mclk);
      wr(16'h1070, 8'h41);
      rc(16'h1071, 8'h05, "abort ready");
      repeat (200) @(posedge mclk);
      rc(16'h1071, 8'h05, "abort noflag");
      start(8'h02);
      repeat (5) @(posedge mclk);
      low_power_entry <= 1'b1;
      rc(16'h1070, 8'h02, "halt starts");
      rc(16'h1071, 8'h05, "halt ready");
      @(posedge mclk);
      low_power_entry <= 1'b0;
   endtask : t_abort
   task automatic t_freeze;
      wr(16'h107F, 8'h20);
      start(8'h03);
      repeat (20) @(posedge mclk);
      emu_suspend <= 1'b1;
      repeat (300) @(posedge mclk);
      rc(16'h1071, 8'h01, "frozen");
      @(posedge mclk);
      emu_suspend <= 1'b0;
      wait_flag();
   endtask : t_freeze
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      t_regs();
      t_conv(1'b0);
      t_conv(1'b1);
      t_abort();
      t_freeze();
      finish_test();
   end
endmodule : test_adccr_top
bind adccr_top adccr_assertions u_chk (.mclk, .rst, .bus_addr, .bus_wr, .bus_wdata,
   .low_power_entry, .emu_suspend, .core_channel, .core_reference, .core_sample,
   .core_convert, .core_ref_supply, .core_frozen, .irq_level1, .irq_level2);
`default_nettype wire
